// ===== common/flash_ctrl_pkg.sv
// What this block does
// - go bit launches operation, hardware clears it
// - go accepted only when enabled and unlocked
// - device reset clears only write-unlock enable
// - enable gates go writes and supply detector
// - failed sequence sets read-only fail flag
// - enabled detector sets sticky low-voltage fault
// - enabled detector drives live low-voltage status
// - operation select writable only while disabled
// - code 0101 erases array unless array protected
// - code 0100 erases page unless protected
// - code 0011 programs row unless protected
// - other codes except 0000 do nothing, reserved too
// - go with code 0000 clears both flags
// - unused bits read zero, all power up zero
package flash_ctrl_pkg;

  localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
  localparam int          GO_BIT        = 15;
  localparam int          UNLOCK_EN_BIT = 14;
  localparam int          FAIL_BIT      = 13;
  localparam int          LVF_BIT       = 12;
  localparam int          LVL_BIT       = 11;
  localparam int          OPSEL_MSB     = 3;
  localparam int          OPSEL_LSB     = 0;
  localparam int          HI_ZERO_MSB   = 31;
  localparam int          HI_ZERO_LSB   = 16;
  localparam int          MID_ZERO_MSB  = 10;
  localparam int          MID_ZERO_LSB  = 4;

  localparam logic        BIT_RESET     = 1'b0;
  localparam logic [3:0]  OPSEL_RESET   = 4'h0;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

  localparam logic [3:0]  OP_NOP_CLEAR  = 4'h0;
  localparam logic [3:0]  OP_NOP_2      = 4'h2;
  localparam logic [3:0]  OP_ROW_PROG   = 4'h3;
  localparam logic [3:0]  OP_PAGE_ERASE = 4'h4;
  localparam logic [3:0]  OP_ARRAY_ERASE = 4'h5;
  localparam logic [3:0]  OP_NOP_6      = 4'h6;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0]
  {
    SEQ_IDLE  = 2'b00,
    SEQ_CHECK = 2'b01,
    SEQ_RUN   = 2'b10,
    SEQ_DONE  = 2'b11
  } seq_state_type;

  function automatic logic is_flash_op(input logic [3:0] op);
    is_flash_op = (op == OP_ROW_PROG) || (op == OP_PAGE_ERASE) ||
                  (op == OP_ARRAY_ERASE);
  endfunction

endpackage

// ===== common/seq_if.sv
`timescale 1ns/1ns
interface seq_if;
  logic       start;
  logic [3:0] op;
  logic       done;
  logic       fail;

  modport ctrl
  (
    output start,
    output op,
    input  done,
    input  fail
  );

  modport seq
  (
    input  start,
    input  op,
    output done,
    output fail
  );
endinterface

// ===== rtl/flash_op_sequencer.sv
`timescale 1ns/1ns
module flash_op_sequencer
(
  input  wire logic hclk,
  input  wire logic por_n,
  seq_if.seq        s,
  output logic       flash_req,
  output logic [3:0] flash_op,
  input  wire logic  page_protected,
  input  wire logic  row_protected,
  input  wire logic  array_protected,
  input  wire logic  flash_done,
  input  wire logic  flash_error
);
  import flash_ctrl_pkg::*;

  seq_state_type state_reg;
  seq_state_type state_next;
  logic [3:0]    op_reg;
  logic [3:0]    op_next;
  logic          fail_reg;
  logic          fail_next;
  logic          blocked;

  always_comb
  begin
    case (op_reg)
      OP_ARRAY_ERASE: blocked = array_protected;
      OP_PAGE_ERASE:  blocked = page_protected;
      OP_ROW_PROG:    blocked = row_protected;
      default:        blocked = 1'b0;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    op_next    = op_reg;
    fail_next  = fail_reg;
    case (state_reg)
      SEQ_IDLE:
      begin
        if (s.start)
        begin
          op_next    = s.op;
          fail_next  = 1'b0;
          state_next = SEQ_CHECK;
        end
      end
      SEQ_CHECK:
      begin
        if (!is_flash_op(op_reg))
          state_next = SEQ_DONE;
        else if (blocked)
        begin
          fail_next  = 1'b1;
          state_next = SEQ_DONE;
        end
        else
          state_next = SEQ_RUN;
      end
      SEQ_RUN:
      begin
        if (flash_done)
        begin
          fail_next  = flash_error;
          state_next = SEQ_DONE;
        end
      end
      SEQ_DONE: state_next = SEQ_IDLE;
      default:  state_next = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge por_n)
  begin
    if (!por_n)
    begin
      state_reg <= SEQ_IDLE;
      op_reg    <= OPSEL_RESET;
      fail_reg  <= BIT_RESET;
    end
    else
    begin
      state_reg <= state_next;
      op_reg    <= op_next;
      fail_reg  <= fail_next;
    end
  end

  assign flash_req = (state_reg == SEQ_RUN);
  assign flash_op  = op_reg;
  assign s.done    = (state_reg == SEQ_DONE);
  assign s.fail    = fail_reg;
endmodule

// ===== rtl/flash_program_erase_control.sv
`timescale 1ns/1ns
module flash_program_erase_control
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        por_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        unlock_pulse,
  input  wire logic        supply_low,
  output logic             detector_enable,
  output logic             flash_req,
  output logic [3:0]       flash_op,
  input  wire logic        page_protected,
  input  wire logic        row_protected,
  input  wire logic        array_protected,
  input  wire logic        flash_done,
  input  wire logic        flash_error
);
  import flash_ctrl_pkg::*;

  seq_if sq ();

  // bus state
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic        rd_pend_reg;
  logic        rd_pend_next;
  logic        hit_reg;
  logic        hit_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  // control register state
  logic        go_reg;
  logic        go_next;
  logic        unlock_en_reg;
  logic        unlock_en_next;
  logic        fail_reg;
  logic        fail_next;
  logic        lvf_reg;
  logic        lvf_next;
  logic        lvl_reg;
  logic        lvl_next;
  logic [3:0]  opsel_reg;
  logic [3:0]  opsel_next;
  logic        armed_reg;
  logic        armed_next;

  logic        addr_take;
  logic        wr_commit;
  logic        launch;
  logic        clear_flags;
  logic        unlock_en_rst_n;
  logic [31:0] read_word;

  // address phase acceptance
  always_comb
  begin
    addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  end

  always_comb
  begin
    wr_pend_next = 1'b0;
    rd_pend_next = 1'b0;
    hit_next     = hit_reg;
    if (addr_take)
    begin
      wr_pend_next = hwrite;
      rd_pend_next = !hwrite;
      hit_next     = (haddr == CTRL_OFFSET);
    end
  end

  always_comb
  begin
    read_word                            = WORD_ZERO;
    read_word[GO_BIT]                    = go_reg;
    read_word[UNLOCK_EN_BIT]             = unlock_en_reg;
    read_word[FAIL_BIT]                  = fail_reg;
    read_word[LVF_BIT]                   = lvf_reg;
    read_word[LVL_BIT]                   = lvl_reg;
    read_word[OPSEL_MSB:OPSEL_LSB]       = opsel_reg;
  end

  // reads take one wait state so a preceding write is visible
  always_comb
  begin
    hrdata_next = hrdata_reg;
    if (rd_pend_reg)
      hrdata_next = hit_reg ? read_word : WORD_ZERO;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hit_reg     <= 1'b0;
      hrdata_reg  <= WORD_ZERO;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      hit_reg     <= hit_next;
      hrdata_reg  <= hrdata_next;
    end
  end

  assign hreadyout = !rd_pend_reg;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_reg;

  // write data phase commits to the control register
  always_comb
  begin
    wr_commit = wr_pend_reg && hit_reg;
  end

  always_comb
  begin
    launch = wr_commit && hwdata[GO_BIT] && !go_reg &&
             unlock_en_reg && armed_reg;
    clear_flags = launch && (opsel_reg == OP_NOP_CLEAR);
  end

  // unlock qualifier: any control write consumes it
  always_comb
  begin
    armed_next = armed_reg;
    if (wr_commit)
      armed_next = 1'b0;
    if (unlock_pulse)
      armed_next = 1'b1;
  end

  always_comb
  begin
    unlock_en_next = unlock_en_reg;
    opsel_next     = opsel_reg;
    go_next        = go_reg;
    if (wr_commit)
    begin
      unlock_en_next = hwdata[UNLOCK_EN_BIT];
      if (!unlock_en_reg)
        opsel_next = hwdata[OPSEL_MSB:OPSEL_LSB];
    end
    if (launch)
      go_next = 1'b1;
    else if (sq.done)
      go_next = 1'b0;
  end

  // flags: a set in the clearing cycle wins
  always_comb
  begin
    fail_next = fail_reg;
    lvf_next  = lvf_reg;
    if (clear_flags)
    begin
      fail_next = 1'b0;
      lvf_next  = 1'b0;
    end
    if (sq.done && sq.fail)
      fail_next = 1'b1;
    if (unlock_en_reg && supply_low)
      lvf_next = 1'b1;
    lvl_next = unlock_en_reg && supply_low;
  end

  assign unlock_en_rst_n = hresetn && por_n;

  always_ff @(posedge hclk or negedge unlock_en_rst_n)
  begin
    if (!unlock_en_rst_n)
      unlock_en_reg <= BIT_RESET;
    else
      unlock_en_reg <= unlock_en_next;
  end

  always_ff @(posedge hclk or negedge por_n)
  begin
    if (!por_n)
    begin
      go_reg    <= BIT_RESET;
      fail_reg  <= BIT_RESET;
      lvf_reg   <= BIT_RESET;
      lvl_reg   <= BIT_RESET;
      opsel_reg <= OPSEL_RESET;
      armed_reg <= BIT_RESET;
    end
    else
    begin
      go_reg    <= go_next;
      fail_reg  <= fail_next;
      lvf_reg   <= lvf_next;
      lvl_reg   <= lvl_next;
      opsel_reg <= opsel_next;
      armed_reg <= armed_next;
    end
  end

  assign detector_enable = unlock_en_reg;
  assign sq.start        = launch;
  assign sq.op           = opsel_reg;

  flash_op_sequencer u_seq
  (
    .hclk            (hclk),
    .por_n           (por_n),
    .s               (sq),
    .flash_req       (flash_req),
    .flash_op        (flash_op),
    .page_protected  (page_protected),
    .row_protected   (row_protected),
    .array_protected (array_protected),
    .flash_done      (flash_done),
    .flash_error     (flash_error)
  );

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || !por_n);

  AST_GO_LAUNCH: assert property (
    launch |=> go_reg ##1 go_reg)
    else $error("go bit not set on accepted launch");

  AST_GO_CLEAR: assert property (
    go_reg && sq.done |=> !go_reg && !flash_req)
    else $error("go bit not cleared at completion");

  AST_GO_NEEDS_UNLOCK: assert property (
    wr_commit && hwdata[GO_BIT] && !go_reg && !armed_reg |=> !go_reg)
    else $error("go set without unlock");

  AST_GO_NEEDS_ENABLE: assert property (
    wr_commit && hwdata[GO_BIT] && !go_reg && !unlock_en_reg |=> !go_reg)
    else $error("go set while write unlock disabled");

  AST_FAIL_SET: assert property (
    sq.done && sq.fail |=> fail_reg)
    else $error("fail flag not set on failed sequence");

  AST_LVF_SET: assert property (
    unlock_en_reg && supply_low |=> lvf_reg)
    else $error("low voltage fault not captured");

  AST_LVL_TRACK: assert property (
    !unlock_en_reg && !$past(unlock_en_reg) |-> !lvl_reg)
    else $error("live status set with detector off");

  AST_OPSEL_LOCK: assert property (
    wr_commit && unlock_en_reg |=> $stable(opsel_reg))
    else $error("operation select changed while enabled");

  AST_ARRAY_PROT: assert property (
    $rose(flash_req) && flash_op == OP_ARRAY_ERASE |->
      !$past(array_protected))
    else $error("array erase issued while protected");

  AST_PAGE_PROT: assert property (
    $rose(flash_req) && flash_op == OP_PAGE_ERASE |->
      !$past(page_protected))
    else $error("page erase issued while protected");

  AST_ROW_PROT: assert property (
    $rose(flash_req) && flash_op == OP_ROW_PROG |->
      !$past(row_protected))
    else $error("row program issued while protected");

  AST_NOP_QUIET: assert property (
    launch && !is_flash_op(opsel_reg) |=> !flash_req [*3] ##1 !go_reg)
    else $error("no-op code touched the flash");

  AST_FLAG_CLEAR: assert property (
    clear_flags && !supply_low |=> !fail_reg && !lvf_reg)
    else $error("flags not cleared by no-op launch");

  AST_RSVD_ZERO: assert property (
    rd_pend_reg |=> hrdata[HI_ZERO_MSB:HI_ZERO_LSB] == '0 &&
      hrdata[MID_ZERO_MSB:MID_ZERO_LSB] == '0 && hreadyout)
    else $error("reserved bits read non-zero");

  AST_UNLOCK_ONCE: assert property (
    launch && !unlock_pulse |=> !armed_reg)
    else $error("unlock qualifier reused");

  AST_UNLOCK_ARM: assert property (
    unlock_pulse |=> armed_reg)
    else $error("unlock pulse did not arm go");

  AST_GO_HOLD: assert property (
    go_reg && !sq.done |=> go_reg)
    else $error("go bit dropped before completion");

  AST_FAIL_QUIET: assert property (
    sq.done && !sq.fail && !fail_reg |=> !fail_reg)
    else $error("fail flag set on clean completion");

  AST_LVF_GATED: assert property (
    !unlock_en_reg && !lvf_reg |=> !lvf_reg)
    else $error("low voltage fault set with detector off");

  AST_LVL_SET: assert property (
    unlock_en_reg && supply_low |=> lvl_reg)
    else $error("live status missed active low voltage");

  AST_LVL_CLEAR: assert property (
    !supply_low |=> !lvl_reg)
    else $error("live status held after low voltage ended");

  AST_RSVD_CODE: assert property (
    $rose(flash_req) |-> is_flash_op(flash_op))
    else $error("array request for a non-operation code");

  AST_ENABLE_RESET: assert property (
    disable iff (!por_n)
    !hresetn |-> !unlock_en_reg)
    else $error("write unlock enable kept through reset");

  AST_KEEP_ON_RESET: assert property (
    disable iff (!por_n)
    !hresetn |=> $stable(opsel_reg) && $stable(lvf_reg))
    else $error("device reset disturbed retained bits");

  AST_POWER_UP_ZERO: assert property (
    $rose(por_n) |-> read_word == WORD_ZERO && !flash_req)
    else $error("control word not zero at power up");

  COV_ROW_PROG: cover property (
    launch && opsel_reg == OP_ROW_PROG ##[1:20] sq.done);
  COV_BLOCKED: cover property (
    sq.done && sq.fail && !$past(flash_req));
  COV_CLEAR: cover property (clear_flags && fail_reg);
  COV_LOW_VOLT: cover property ($rose(lvl_reg) ##[1:10] $fell(lvl_reg));
endmodule

// ===== bench/flash_array_model.sv
`timescale 1ns/1ns
module flash_array_model
(
  input  wire logic       hclk,
  input  wire logic       por_n,
  input  wire logic       flash_req,
  input  wire logic [3:0] delay,
  input  wire logic       err_in,
  output logic            flash_done,
  output logic            flash_error
);
  logic [4:0] cnt_reg;
  logic       tog_reg;
  // one done pulse per request, after a programmable delay
  always_ff @(posedge hclk or negedge por_n)
  begin
    if (!por_n)
    begin
      cnt_reg    <= 5'h00;
      flash_done <= 1'b0;
      tog_reg    <= 1'b0;
    end
    else
    begin
      tog_reg    <= !tog_reg;
      cnt_reg    <= flash_req ? cnt_reg + 5'h01 : 5'h00;
      flash_done <= flash_req && !flash_done &&
                    (cnt_reg == {1'b0, delay});
    end
  end
  // error line carries nothing useful outside the done pulse
  assign flash_error = flash_done ? err_in : tog_reg;
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
  import flash_ctrl_pkg::*;
  logic        hclk, hresetn, por_n, hsel, hwrite, unlock_pulse;
  logic        supply_low, page_p, row_p, array_p, err_in;
  logic        req_q = 1'b0;
  logic        hreadyout, hresp, det_en, flash_req, flash_done;
  logic        flash_error, fail_m, lvf_m;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  flash_op, delay, last_op;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          fails, n_checks;
  int          n_req = 0;

  flash_program_erase_control u_dut
  (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .unlock_pulse(unlock_pulse),
    .supply_low(supply_low), .detector_enable(det_en),
    .flash_req(flash_req), .flash_op(flash_op),
    .page_protected(page_p), .row_protected(row_p),
    .array_protected(array_p), .flash_done(flash_done),
    .flash_error(flash_error)
  );

  flash_array_model u_flash
  (
    .hclk(hclk), .por_n(por_n), .flash_req(flash_req), .delay(delay),
    .err_in(err_in), .flash_done(flash_done), .flash_error(flash_error)
  );

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // count rising edges of the array request and latch its code
  always @(posedge hclk)
  begin
    if (flash_req === 1'b1 && req_q !== 1'b1)
    begin
      n_req++;
      last_op = flash_op;
    end
    req_q = flash_req;
  end

  task finish_test;
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] full(input logic go, en, f, lf, ll,
                                       input logic [3:0] op);
    full = WORD_ZERO;
    full[GO_BIT] = go;
    full[UNLOCK_EN_BIT] = en;
    full[FAIL_BIT] = f;
    full[LVF_BIT] = lf;
    full[LVL_BIT] = ll;
    full[OPSEL_MSB:OPSEL_LSB] = op;
  endfunction

  task automatic ahb(input logic wr, input logic [31:0] a, wd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 20);
    rd = hrdata;
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    if (n >= 20)
    begin
      fails++;
      finish_test();
    end
  endtask

  task pulse_unlock;
    @(posedge hclk);
    unlock_pulse <= 1'b1;
    @(posedge hclk);
    unlock_pulse <= 1'b0;
  endtask

  task automatic launch(input logic [3:0] op);
    logic isop, prot;
    int   n, r0;
    ahb(1'b1, CTRL_OFFSET, full(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, op));
    ahb(1'b1, CTRL_OFFSET, full(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, op));
    pulse_unlock();
    isop = (op == 4'h3) || (op == 4'h4) || (op == 4'h5);
    prot = (op == 4'h3) ? row_p : (op == 4'h4) ? page_p :
           (op == 4'h5) ? array_p : 1'b0;
    r0 = n_req;
    ahb(1'b1, CTRL_OFFSET, full(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, op));
    n = 0;
    do begin ahb(1'b0, CTRL_OFFSET, 32'h0); n++; end
    while (rd[GO_BIT] !== 1'b0 && n < 30);
    if (n >= 30)
    begin
      fails++;
      finish_test();
    end
    fail_m = (op == 4'h0) ? 1'b0 : fail_m | (isop & (prot | err_in));
    lvf_m = (op == 4'h0) ? 1'b0 : lvf_m;
    check(n_req - r0, {31'h0, isop & !prot});
    if (isop & !prot)
      check({28'h0, last_op}, {28'h0, op});
    check(rd, full(1'b0, 1'b1, fail_m, lvf_m, 1'b0, op));
  endtask

  initial
  begin
    {hresetn, por_n, hsel, hwrite, unlock_pulse, supply_low} = 6'h00;
    {page_p, row_p, array_p, err_in, fail_m, lvf_m} = 6'h00;
    fails = 0;
    n_checks = 0;
    htrans = 2'h0;
    hsize = 3'h2;
    delay = 4'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    void'($urandom(78146));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, WORD_ZERO);
    ahb(1'b1, 32'h0000_0010, full(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h5));
    ahb(1'b0, 32'h0000_0010, 32'h0);
    check(rd, WORD_ZERO);
    ahb(1'b1, CTRL_OFFSET, full(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3));
    ahb(1'b1, CTRL_OFFSET, full(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h3));
    @(negedge hclk);
    check({31'h0, det_en}, 32'h1);
    ahb(1'b1, CTRL_OFFSET, full(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h9));
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, full(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h3));
    ahb(1'b1, CTRL_OFFSET, full(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3));
    pulse_unlock();
    ahb(1'b1, CTRL_OFFSET, full(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3));
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, full(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3));
    check({31'h0, det_en}, 32'h0);
    supply_low <= 1'b1;
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, full(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h3));
    ahb(1'b1, CTRL_OFFSET, full(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h3));
    repeat (3) @(posedge hclk);
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, full(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'h3));
    supply_low <= 1'b0;
    repeat (3) @(posedge hclk);
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, full(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'h3));
    lvf_m = 1'b1;
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, CTRL_OFFSET, 32'h0);
    check(rd, full(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h3));
    err_in <= 1'b1;
    launch(OP_ROW_PROG);
    err_in <= 1'b0;
    page_p <= 1'b1;
    launch(OP_PAGE_ERASE);
    page_p <= 1'b0;
    launch(OP_NOP_CLEAR);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge hclk);
      {page_p, row_p, array_p, err_in} <= 4'($urandom);
      delay <= 4'($urandom);
      launch(4'(i));
    end
    finish_test();
  end
endmodule
